// ===== abu_pkg.sv
`default_nettype none
package abu_pkg;
    // APB address width: word index of the highest register, times four
    localparam int ADDR_W = 18;

    // Register word indices; byte address is four times the index
    localparam logic [15:0] IDX_WAIT_STATUS = 16'hfe00;
    localparam logic [15:0] IDX_FLAG_CLEAR = 16'hfe03;
    localparam logic [15:0] IDX_ADDR_HIGH = 16'hfe09;
    localparam logic [15:0] IDX_ADDR_LOW = 16'hfe0a;
    localparam logic [15:0] IDX_STATUS_CTRL = 16'hfe0b;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'hfe10;
    localparam logic [15:0] IDX_IRQ_MASK = 16'hfe11;

    // Field positions
    localparam int BIT_ENABLE = 7;
    localparam int BIT_ACTIVE = 6;
    localparam int BIT_WAIT_EXIT = 1;
    localparam int BIT_FLAG_CLEAR = 7;
    localparam int IRQ_W = 3;
    localparam int IRQ_TAKEN = 0;
    localparam int IRQ_WAIT = 1;
    localparam int IRQ_END = 2;

    // Fixed read value of the wait status register (bit 4 reads one)
    localparam logic [7:0] WAIT_STATUS_FIXED = 8'h10;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

    // Break vectors
    localparam logic [15:0] VEC_NORMAL = 16'hfffc;
    localparam logic [15:0] VEC_MONITOR = 16'hfefc;

    typedef enum logic [2:0] {
        REG_NONE,
        REG_WAIT,
        REG_FLAG,
        REG_ADDRH,
        REG_ADDRL,
        REG_SCR,
        REG_ISTAT,
        REG_IMASK
    } abu_reg_t;

    typedef enum logic {
        PH_RUN,
        PH_BREAK
    } abu_phase_t;

    // Address decode shared by read and write paths
    function automatic abu_reg_t abu_decode(input logic [ADDR_W-1:0] addr);
        abu_reg_t r;
        r = REG_NONE;
        if (addr[1:0] == 2'h0) begin
            case (addr[ADDR_W-1:2])
                IDX_WAIT_STATUS: r = REG_WAIT;
                IDX_FLAG_CLEAR: r = REG_FLAG;
                IDX_ADDR_HIGH: r = REG_ADDRH;
                IDX_ADDR_LOW: r = REG_ADDRL;
                IDX_STATUS_CTRL: r = REG_SCR;
                IDX_IRQ_STATUS: r = REG_ISTAT;
                IDX_IRQ_MASK: r = REG_IMASK;
                default: r = REG_NONE;
            endcase
        end
        return r;
    endfunction
endpackage
`default_nettype wire

// ===== abu_cmp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface abu_cmp_if;
    logic [15:0] cpu_addr;
    logic pc_valid;
    logic opcode_fetch;
    logic [15:0] brk_addr;
    logic enable;
    logic armed;
    logic hit_opcode;
    logic hit_operand;

    modport top (
        output cpu_addr, pc_valid, opcode_fetch, brk_addr, enable, armed,
        input hit_opcode, hit_operand
    );
    modport cmp (
        input cpu_addr, pc_valid, opcode_fetch, brk_addr, enable, armed,
        output hit_opcode, hit_operand
    );
endinterface
`default_nettype wire

// ===== abu_match.sv
`timescale 1ns/1ps
`default_nettype none
module abu_match (
    // Comparison bus from the control block
    abu_cmp_if.cmp cmp
);
    logic live;

    // Full 16-bit compare, program-counter addresses only
    // enable and PC qualify
    always_comb begin
        live = cmp.enable && cmp.pc_valid && cmp.armed && (cmp.cpu_addr == cmp.brk_addr);
        cmp.hit_opcode = live && cmp.opcode_fetch;
        cmp.hit_operand = live && !cmp.opcode_fetch;
    end
endmodule
`default_nettype wire

// ===== abu_top.sv
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module abu_top #(
    parameter logic [7:0] SWI_OPCODE = 8'h00
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [abu_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // CPU core signals
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_pc_valid,
    input wire logic cpu_opcode_fetch,
    input wire logic cpu_instr_boundary,
    input wire logic cpu_rti_exec,
    input wire logic cpu_in_wait,
    input wire logic monitor_mode,
    // Reset pin test voltage detect
    input wire logic high_test_voltage,
    // Toward the system integration unit
    output logic break_request,
    output logic [7:0] swi_opcode_out,
    output logic [15:0] break_vector,
    output logic break_state_out,
    // Peripheral controls
    output logic counter_unit_one_stop,
    output logic counter_unit_two_stop,
    output logic watchdog_hold,
    output logic flag_clear_allowed,
    // Interrupt
    output logic irq
);
    abu_cmp_if cmp_bus ();

    abu_pkg::abu_phase_t phase;
    abu_pkg::abu_reg_t sel;
    logic [15:0] brk_addr;
    logic break_enable;
    logic break_active;
    logic armed;
    logic pend;
    logic wait_exit;
    logic flag_clear_enable;
    logic [abu_pkg::IRQ_W-1:0] irq_status;
    logic [abu_pkg::IRQ_W-1:0] irq_mask;
    logic [abu_pkg::IRQ_W-1:0] irq_events;
    logic hv_meta;
    logic hv_sync;
    logic wr_en;
    logic setup;
    logic sw_force;
    logic any_hit;
    logic rti_end;
    logic [7:0] wr_byte;
    logic wr_enable_bit;
    logic [7:0] rd_byte;

    // Comparator hookup
    assign cmp_bus.cpu_addr = cpu_addr;
    assign cmp_bus.pc_valid = cpu_pc_valid;
    assign cmp_bus.opcode_fetch = cpu_opcode_fetch;
    assign cmp_bus.brk_addr = brk_addr;
    assign cmp_bus.enable = break_enable;
    assign cmp_bus.armed = armed;

    abu_match u_match (
        .cmp(cmp_bus)
    );

    // Bus decode; zero-wait slave so access phase completes at once
    assign sel = abu_pkg::abu_decode(paddr);
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && pstrb[0] && (sel != abu_pkg::REG_NONE);
    assign wr_byte = pwdata[7:0];
    assign wr_enable_bit = pwdata[abu_pkg::BIT_ENABLE];
    assign pready = 1'b1;
    assign pslverr = psel && penable && (sel == abu_pkg::REG_NONE);
    assign sw_force = wr_en && (sel == abu_pkg::REG_SCR) && pwdata[abu_pkg::BIT_ACTIVE];
    assign any_hit = cmp_bus.hit_opcode || cmp_bus.hit_operand;
    assign rti_end = (phase == abu_pkg::PH_BREAK) && cpu_rti_exec;

    // Opcode hit breaks in the fetch cycle so the opcode is replaced;
    // pended breaks wait for the instruction boundary
    // request toward integration unit
    always_comb begin
        break_request = (phase == abu_pkg::PH_RUN) &&
            (cmp_bus.hit_opcode || (pend && cpu_instr_boundary));
    end

    // Pending break from operand hit or software write
    // operand hit deferred to boundary
    // operand placement only delays the break
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pend <= 1'b0;
        end else if (cmp_bus.hit_operand || sw_force) begin
            pend <= 1'b1;
        end else if (break_request) begin
            pend <= 1'b0;
        end
    end

    // Break phase
    // return ends break state
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            phase <= abu_pkg::PH_RUN;
        end else begin
            unique case (phase)
                abu_pkg::PH_RUN: begin
                    if (break_request) begin
                        phase <= abu_pkg::PH_BREAK;
                    end
                end
                abu_pkg::PH_BREAK: begin
                    if (cpu_rti_exec) begin
                        phase <= abu_pkg::PH_RUN;
                    end
                end
            endcase
        end
    end

    // Break enable control
    // enable bit write and reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            break_enable <= 1'b0;
        end else if (wr_en && (sel == abu_pkg::REG_SCR)) begin
            break_enable <= wr_enable_bit;
        end
    end

    // Active bit; a match in the clearing cycle wins
    // set by match, forced or cleared by write
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            break_active <= 1'b0;
        end else if (any_hit || sw_force) begin
            break_active <= 1'b1;
        end else if (wr_en && (sel == abu_pkg::REG_SCR)) begin
            break_active <= 1'b0;
        end
    end

    // Break address bytes
    // address halves, cleared on reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            brk_addr <= abu_pkg::ADDR_RESET;
        end else if (wr_en && (sel == abu_pkg::REG_ADDRH)) begin
            brk_addr[15:8] <= wr_byte;
        end else if (wr_en && (sel == abu_pkg::REG_ADDRL)) begin
            brk_addr[7:0] <= wr_byte;
        end
    end

    // One match per programmed address; the return lands on the same
    // opcode, so without this it would break again at once
    // no rearm without new address
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            armed <= 1'b1;
        end else if (wr_en && ((sel == abu_pkg::REG_ADDRH) || (sel == abu_pkg::REG_ADDRL))) begin
            armed <= 1'b1;
        end else if (any_hit) begin
            armed <= 1'b0;
        end
    end

    // Wait exit flag, set beats clear; writing one has no effect
    // wait exit flag
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wait_exit <= 1'b0;
        end else if (break_request && cpu_in_wait) begin
            wait_exit <= 1'b1;
        end else if (wr_en && (sel == abu_pkg::REG_WAIT) && !pwdata[abu_pkg::BIT_WAIT_EXIT]) begin
            wait_exit <= 1'b0;
        end
    end

    // Flag clear enable
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flag_clear_enable <= 1'b0;
        end else if (wr_en && (sel == abu_pkg::REG_FLAG)) begin
            flag_clear_enable <= pwdata[abu_pkg::BIT_FLAG_CLEAR];
        end
    end

    // Interrupt status: sticky, write one to clear, set wins
    always_comb begin
        irq_events = abu_pkg::IRQ_RESET;
        irq_events[abu_pkg::IRQ_TAKEN] = break_request;
        irq_events[abu_pkg::IRQ_WAIT] = break_request && cpu_in_wait;
        irq_events[abu_pkg::IRQ_END] = rti_end;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_status <= abu_pkg::IRQ_RESET;
        end else if (wr_en && (sel == abu_pkg::REG_ISTAT)) begin
            irq_status <= (irq_status & ~wr_byte[abu_pkg::IRQ_W-1:0]) | irq_events;
        end else begin
            irq_status <= irq_status | irq_events;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_mask <= abu_pkg::IRQ_RESET;
        end else if (wr_en && (sel == abu_pkg::REG_IMASK)) begin
            irq_mask <= wr_byte[abu_pkg::IRQ_W-1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    // Test voltage comes from a pin: two-stage synchroniser
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hv_meta <= 1'b0;
            hv_sync <= 1'b0;
        end else begin
            hv_meta <= high_test_voltage;
            hv_sync <= hv_meta;
        end
    end

    // Vector tracks the mode one cycle late; mode is static in practice
    // vector selection
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            break_vector <= abu_pkg::VEC_NORMAL;
        end else begin
            break_vector <= monitor_mode ? abu_pkg::VEC_MONITOR : abu_pkg::VEC_NORMAL;
        end
    end

    assign swi_opcode_out = SWI_OPCODE;
    assign break_state_out = (phase == abu_pkg::PH_BREAK);
    assign flag_clear_allowed = (phase == abu_pkg::PH_RUN) || flag_clear_enable;
    assign counter_unit_one_stop = (phase == abu_pkg::PH_BREAK);
    assign counter_unit_two_stop = (phase == abu_pkg::PH_BREAK);
    assign watchdog_hold = (phase == abu_pkg::PH_BREAK) && hv_sync;

    // Read mux
    always_comb begin
        rd_byte = 8'h00;
        unique case (sel)
            abu_pkg::REG_WAIT: begin
                rd_byte = abu_pkg::WAIT_STATUS_FIXED;
                rd_byte[abu_pkg::BIT_WAIT_EXIT] = wait_exit;
            end
            abu_pkg::REG_FLAG: rd_byte[abu_pkg::BIT_FLAG_CLEAR] = flag_clear_enable;
            abu_pkg::REG_ADDRH: rd_byte = brk_addr[15:8];
            abu_pkg::REG_ADDRL: rd_byte = brk_addr[7:0];
            abu_pkg::REG_SCR: begin
                rd_byte[abu_pkg::BIT_ENABLE] = break_enable;
                rd_byte[abu_pkg::BIT_ACTIVE] = break_active;
            end
            abu_pkg::REG_ISTAT: rd_byte[abu_pkg::IRQ_W-1:0] = irq_status;
            abu_pkg::REG_IMASK: rd_byte[abu_pkg::IRQ_W-1:0] = irq_mask;
            abu_pkg::REG_NONE: rd_byte = 8'h00;
        endcase
    end

    // Read data captured in setup, valid through the access cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (setup && !pwrite) begin
            prdata <= {24'h000000, rd_byte};
        end
    end

    // Checks
    default clocking abu_cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    AST_OPCODE_BREAK: assert property (
        (cmp_bus.hit_opcode && phase == abu_pkg::PH_RUN) |-> break_request ##1 (phase == abu_pkg::PH_BREAK)
    ) else $error("opcode hit did not enter break");

    AST_REQ_CAUSE: assert property (
        break_request |-> (cmp_bus.hit_opcode || pend)
    ) else $error("break request without cause");

    AST_VECTOR: assert property (
        break_request |-> (break_vector == ($past(monitor_mode) ? abu_pkg::VEC_MONITOR : abu_pkg::VEC_NORMAL))
    ) else $error("wrong break vector");

    AST_SW_FORCE: assert property (
        (sw_force && !break_request) |=> pend && break_active
    ) else $error("software break not pended");

    AST_OPERAND_DEFER: assert property (
        (cmp_bus.hit_operand && !pend) |-> !break_request ##1 pend
    ) else $error("operand hit not deferred");

    AST_RTI_END: assert property (
        rti_end |=> (phase == abu_pkg::PH_RUN) && irq_status[abu_pkg::IRQ_END]
    ) else $error("return did not end break");

    AST_NO_REARM: assert property (
        (any_hit && !wr_en) |=> !cmp_bus.hit_opcode && !cmp_bus.hit_operand
    ) else $error("break repeated without new address");

    AST_ENABLE_WR: assert property (
        (wr_en && sel == abu_pkg::REG_SCR) |=> (break_enable == $past(wr_enable_bit))
    ) else $error("enable bit write lost");

    AST_ADDR_WR: assert property (
        (wr_en && sel == abu_pkg::REG_ADDRH) |=> (brk_addr[15:8] == $past(wr_byte))
    ) else $error("high address byte write lost");

    AST_WAIT_FLAG: assert property (
        (break_request && cpu_in_wait) |=> wait_exit
    ) else $error("wait exit flag not set");

    AST_FLAG_GATE: assert property (
        (phase == abu_pkg::PH_BREAK && !flag_clear_enable) |-> !flag_clear_allowed
    ) else $error("flags clearable in break");

    AST_TIMER_STOP: assert property (
        $rose(phase == abu_pkg::PH_BREAK) |-> counter_unit_one_stop && counter_unit_two_stop
    ) else $error("counters not frozen");

    AST_WDOG: assert property (
        watchdog_hold |-> (phase == abu_pkg::PH_BREAK) && $past(hv_meta)
    ) else $error("watchdog hold without cause");

    COV_OPCODE: cover property (cmp_bus.hit_opcode ##1 phase == abu_pkg::PH_BREAK);
    COV_SOFT: cover property (sw_force ##[1:20] break_request);
    COV_RETURN: cover property (rti_end ##1 phase == abu_pkg::PH_RUN);
    COV_WAIT: cover property (break_request && cpu_in_wait);
endmodule
`default_nettype wire

// ===== abu_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module abu_cpu_model (
    // Clock and break input
    input wire logic core_clk,
    input wire logic break_request,
    // CPU bus toward the unit
    output logic [15:0] cpu_addr,
    output logic cpu_pc_valid,
    output logic cpu_opcode_fetch,
    output logic cpu_instr_boundary,
    output logic cpu_rti_exec
);
    logic brk_seen;
    logic exec_done;

    // Bus idle at time zero
    initial begin
        cpu_addr = 16'h5a5a;
        cpu_pc_valid = 1'b0;
        cpu_opcode_fetch = 1'b0;
        cpu_instr_boundary = 1'b0;
        cpu_rti_exec = 1'b0;
        brk_seen = 1'b0;
        exec_done = 1'b0;
    end

    // Opcode then operands; a break on the opcode cycle aborts the instruction
    task automatic run_instr(input logic [15:0] a, input int len);
        int i;
        brk_seen = 1'b0;
        for (i = 0; i < len; i++) begin
            @(posedge core_clk);
            cpu_addr <= a + 16'(i);
            cpu_pc_valid <= 1'b1;
            cpu_opcode_fetch <= (i == 0);
            cpu_instr_boundary <= (i == len - 1);
            @(negedge core_clk);
            if (break_request === 1'b1) brk_seen = 1'b1;
            if (brk_seen && i == 0) break;
        end
        exec_done = (i == len);
        @(posedge core_clk);
        // Released bus never repeats the last address
        cpu_addr <= ~cpu_addr;
        cpu_pc_valid <= 1'b0;
        cpu_opcode_fetch <= 1'b0;
        cpu_instr_boundary <= 1'b0;
    endtask

    // Return from the handler, one-cycle pulse
    task automatic return_from_interrupt_opcode();
        @(posedge core_clk);
        cpu_rti_exec <= 1'b1;
        @(posedge core_clk);
        cpu_rti_exec <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [7:0] SOFTWARE_INTERRUPT_OPCODE = 8'h5a;
    localparam logic [15:0] WS = abu_pkg::IDX_WAIT_STATUS;
    localparam logic [15:0] SCR = abu_pkg::IDX_STATUS_CTRL;
    localparam logic [15:0] IST = abu_pkg::IDX_IRQ_STATUS;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [abu_pkg::ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic cpu_in_wait = 1'b0;
    logic monitor_mode = 1'b0;
    logic high_test_voltage = 1'b0;
    logic snap = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, cpu_pc_valid, cpu_opcode_fetch, cpu_instr_boundary, cpu_rti_exec;
    logic [15:0] cpu_addr, break_vector, a;
    logic [7:0] swi_opcode_out, rh, rl;
    logic break_request, break_state_out, counter_unit_one_stop, counter_unit_two_stop;
    logic watchdog_hold, flag_clear_allowed, irq;
    logic [32:0] expq[$];
    int errors = 0;
    int checked = 0;
    integer seed = 32'h1aa2f314;
    wire [32:0] obs = {1'b0, break_vector, swi_opcode_out, cpu.exec_done, cpu.brk_seen, break_state_out,
        counter_unit_one_stop, counter_unit_two_stop, watchdog_hold, flag_clear_allowed, irq};

    always #5 core_clk = ~core_clk;

    abu_top #(.SWI_OPCODE(SOFTWARE_INTERRUPT_OPCODE)) dut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .cpu_addr, .cpu_pc_valid, .cpu_opcode_fetch, .cpu_instr_boundary,
        .cpu_rti_exec, .cpu_in_wait, .monitor_mode, .high_test_voltage, .break_request, .swi_opcode_out,
        .break_vector, .break_state_out, .counter_unit_one_stop, .counter_unit_two_stop, .watchdog_hold,
        .flag_clear_allowed, .irq);
    abu_cpu_model cpu (.core_clk, .break_request, .cpu_addr, .cpu_pc_valid, .cpu_opcode_fetch,
        .cpu_instr_boundary, .cpu_rti_exec);

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("errors %0d, checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One APB transfer; a read notes its expected {pslverr, prdata}
    task automatic apb(input logic [15:0] idx, input logic wr, input logic [7:0] d, input logic [3:0] s,
        input logic [32:0] e);
        @(posedge core_clk);
        if (!wr) expq.push_back(e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        pstrb <= s;
        penable <= 1'b0;
        @(posedge core_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the slave's answer
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        apb(idx, 1'b1, d, 4'hf, 33'h0);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [7:0] e);
        apb(idx, 1'b0, 8'h0, 4'hf, {25'h0, e});
    endtask

    // Snapshot after settling: f = done, seen, state x3, watchdog, flag clear, irq
    task automatic snapx(input logic [15:0] v, input logic [7:0] f);
        repeat (4) @(posedge core_clk);
        expq.push_back({1'b0, v, SOFTWARE_INTERRUPT_OPCODE, f});
        snap <= 1'b1;
        @(posedge core_clk);
        snap <= 1'b0;
    endtask

    // Oldest note against whatever result shows up
    always @(negedge core_clk) begin
        if (snap || (psel && penable && !pwrite && pready === 1'b1)) begin
            if (expq.size() == 0) begin
                errors++;
                $display("unexpected at %0t: result with no note", $time);
            end else begin
                check(snap ? obs : {pslverr, prdata}, expq.pop_front());
            end
        end
    end

    // Whole run needs well under a thousand cycles
    initial begin
        #200000;
        errors++;
        complete_run();
    end

    initial begin
        rh = 8'($random(seed));
        rl = 8'($random(seed)) & 8'h7f;
        a = {rh, rl};
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(WS, 8'h10);
        rd(abu_pkg::IDX_FLAG_CLEAR, 8'h00);
        rd(abu_pkg::IDX_ADDR_HIGH, 8'h00);
        rd(abu_pkg::IDX_ADDR_LOW, 8'h00);
        rd(SCR, 8'h00);
        rd(IST, 8'h00);
        rd(abu_pkg::IDX_IRQ_MASK, 8'h00);
        apb(16'hfe01, 1'b0, 8'h0, 4'hf, {1'b1, 32'h0});
        snapx(16'hfffc, 8'h02);
        wr(abu_pkg::IDX_ADDR_HIGH, rh);
        wr(abu_pkg::IDX_ADDR_LOW, rl);
        apb(abu_pkg::IDX_ADDR_LOW, 1'b1, ~rl, 4'h0, 33'h0);
        rd(abu_pkg::IDX_ADDR_HIGH, rh);
        rd(abu_pkg::IDX_ADDR_LOW, rl);
        cpu.run_instr(a, 3);
        snapx(16'hfffc, 8'h82);
        // opcode break in wait with test voltage
        wr(SCR, 8'h80);
        high_test_voltage <= 1'b1;
        cpu_in_wait <= 1'b1;
        cpu.run_instr(a, 3);
        snapx(16'hfffc, 8'h7c);
        rd(SCR, 8'hc0);
        rd(WS, 8'h12);
        rd(IST, 8'h03);
        wr(WS, 8'h00);
        rd(WS, 8'h10);
        wr(abu_pkg::IDX_FLAG_CLEAR, 8'h80);
        wr(abu_pkg::IDX_IRQ_MASK, 8'h07);
        snapx(16'hfffc, 8'h7f);
        // return, same address gives no new break
        high_test_voltage <= 1'b0;
        cpu_in_wait <= 1'b0;
        wr(SCR, 8'h80);
        cpu.return_from_interrupt_opcode();
        snapx(16'hfffc, 8'h43);
        rd(IST, 8'h07);
        wr(IST, 8'h07);
        rd(IST, 8'h00);
        cpu.run_instr(a, 3);
        snapx(16'hfffc, 8'h82);
        wr(abu_pkg::IDX_ADDR_LOW, rl + 8'h01);
        monitor_mode <= 1'b1;
        cpu.run_instr(a, 3);
        snapx(16'hfefc, 8'hfb);
        // handler moves address onto an opcode
        wr(abu_pkg::IDX_ADDR_LOW, rl);
        wr(SCR, 8'h80);
        cpu.return_from_interrupt_opcode();
        cpu.run_instr(a, 3);
        snapx(16'hfefc, 8'h7b);
        wr(abu_pkg::IDX_FLAG_CLEAR, 8'h00);
        snapx(16'hfefc, 8'h79);
        wr(SCR, 8'h80);
        cpu.return_from_interrupt_opcode();
        monitor_mode <= 1'b0;
        wr(SCR, 8'hc0);
        cpu.run_instr(a + 16'h0010, 2);
        snapx(16'hfffc, 8'hf9);
        rd(SCR, 8'hc0);
        complete_run();
    end
endmodule
`default_nettype wire
